// [hw/etc_pkg.sv]
// Purpose: Shared constants for the edge timed charge control block.
// Assumes: APB slave with 32-bit data, registers of up to 16 bits in the low half.
// Notes:   Offsets are byte addresses of aligned words.
package etc_pkg;
  localparam logic [11:0] ETC_OFS_CTRL   = 12'h000;
  localparam logic [11:0] ETC_OFS_CUR    = 12'h004;
  localparam logic [11:0] ETC_OFS_STAT   = 12'h008;
  localparam logic [11:0] ETC_OFS_MASK   = 12'h00C;
  localparam int          ETC_B_EN       = 15;
  localparam int          ETC_B_IDLE     = 13;
  localparam int          ETC_B_DGEN     = 12;
  localparam int          ETC_B_PASS     = 11;
  localparam int          ETC_B_ORDER    = 10;
  localparam int          ETC_B_GND      = 9;
  localparam int          ETC_B_TRIG     = 8;
  localparam int          ETC_B_POL2     = 7;
  localparam int          ETC_B_SRC2     = 5;
  localparam int          ETC_B_POL1     = 4;
  localparam int          ETC_B_SRC1     = 2;
  localparam int          ETC_B_SEEN2    = 1;
  localparam int          ETC_B_SEEN1    = 0;
  localparam logic [15:0] ETC_CTRL_WMASK = 16'hBFFF;
  localparam logic [15:0] ETC_CUR_WMASK  = 16'hFF00;
  localparam logic [15:0] ETC_CTRL_RST   = 16'h0000;
  localparam logic [15:0] ETC_CUR_RST    = 16'h0000;
  localparam int          ETC_B_TRIM     = 10;
  localparam int          ETC_B_RANGE    = 8;
  localparam int          ETC_I_SEEN1    = 0;
  localparam int          ETC_I_SEEN2    = 1;
  localparam int          ETC_I_PULSE    = 2;
  localparam int          ETC_IRQ_W      = 3;
  localparam logic [1:0]  ETC_SRC_TIMER  = 2'h0;
  localparam logic [1:0]  ETC_SRC_OCMP   = 2'h1;
  localparam logic [1:0]  ETC_SRC_PIN2   = 2'h2;
  localparam logic [1:0]  ETC_SRC_PIN1   = 2'h3;
  localparam logic [1:0]  ETC_RNG_OFF    = 2'h0;
  typedef enum logic [1:0] {
    ETC_DG_IDLE   = 2'b00,
    ETC_DG_CHARGE = 2'b01,
    ETC_DG_DONE   = 2'b10
  } etc_dg_state_t;
endpackage : etc_pkg

// [hw/etc_edge_qual.sv]
// Purpose: Selects one edge source and detects the chosen polarity.
// Assumes: Sources are synchronous to pclk.
// Notes:   Pulse is one cycle wide.
`timescale 1ns/1ns
module etc_edge_qual
  import etc_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [1:0] sel,
  input  wire logic       rising,
  input  wire logic       timer_evt,
  input  wire logic       ocmp_evt,
  input  wire logic       pin_one,
  input  wire logic       pin_two,
  output logic            edge_pulse
);
  logic src;
  logic src_reg;

  always_comb begin
    unique case (sel)
      ETC_SRC_PIN1:  src = pin_one;
      ETC_SRC_PIN2:  src = pin_two;
      ETC_SRC_OCMP:  src = ocmp_evt;
      ETC_SRC_TIMER: src = timer_evt;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_reg <= 1'b0;
    end else begin
      src_reg <= src;
    end
  end

  assign edge_pulse = rising ? (src & ~src_reg) : (~src & src_reg);
endmodule : etc_edge_qual

// [hw/etc_top.sv]
// Purpose: Digital control of a charge time measurement unit behind APB.
// Assumes: All inputs synchronous to pclk; comparator output level from analog side.
// Notes:   APB answers with zero wait states.
//
// Implementation choices: register access over APB and the register addresses.
`timescale 1ns/1ns
module etc_top
  import etc_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        idle_mode,
  input  wire logic        timer_evt,
  input  wire logic        ocmp_evt,
  input  wire logic        ext_edge_pin_one,
  input  wire logic        ext_edge_pin_two,
  input  wire logic        comp_trip,
  output logic             charge_on,
  output logic             route_to_comp_b,
  output logic             source_ground,
  output logic      [5:0]  current_trim,
  output logic      [1:0]  current_range,
  output logic             trigger_out,
  output logic             delay_pulse_out,
  output logic             irq
);
  logic [15:0]          ctrl_reg;
  logic [15:0]          cur_reg;
  logic [ETC_IRQ_W-1:0] stat_reg;
  logic [ETC_IRQ_W-1:0] mask_reg;
  etc_dg_state_t        dg_reg;
  logic                 e1_raw;
  logic                 e2_raw;
  logic                 active;
  logic                 e1_ok;
  logic                 e2_ok;
  logic                 wr;
  logic                 rd;
  logic                 dec_ok;
  logic                 pulse_evt;
  logic [15:0]          ctrl_wr;
  logic [ETC_IRQ_W-1:0] evt;

  etc_edge_qual u_edge1 (
    .pclk       (pclk),
    .presetn    (presetn),
    .sel        (ctrl_reg[ETC_B_SRC1+:2]),
    .rising     (ctrl_reg[ETC_B_POL1]),
    .timer_evt  (timer_evt),
    .ocmp_evt   (ocmp_evt),
    .pin_one    (ext_edge_pin_one),
    .pin_two    (ext_edge_pin_two),
    .edge_pulse (e1_raw)
  );

  etc_edge_qual u_edge2 (
    .pclk       (pclk),
    .presetn    (presetn),
    .sel        (ctrl_reg[ETC_B_SRC2+:2]),
    .rising     (ctrl_reg[ETC_B_POL2]),
    .timer_evt  (timer_evt),
    .ocmp_evt   (ocmp_evt),
    .pin_one    (ext_edge_pin_one),
    .pin_two    (ext_edge_pin_two),
    .edge_pulse (e2_raw)
  );

  // Unit runs only when enabled and not halted by idle.
  assign active = ctrl_reg[ETC_B_EN] & ~(ctrl_reg[ETC_B_IDLE] & idle_mode);
  assign e1_ok  = active & ctrl_reg[ETC_B_PASS] & e1_raw;
  assign e2_ok  = active & ctrl_reg[ETC_B_PASS] & e2_raw
                & (~ctrl_reg[ETC_B_ORDER] | ctrl_reg[ETC_B_SEEN1]);

  assign wr     = psel & penable & pwrite;
  assign rd     = psel & ~penable & ~pwrite;
  assign dec_ok = (paddr == ETC_OFS_CTRL) | (paddr == ETC_OFS_CUR)
                | (paddr == ETC_OFS_STAT) | (paddr == ETC_OFS_MASK);
  assign pulse_evt = (dg_reg == ETC_DG_CHARGE) & comp_trip;
  assign evt = {pulse_evt, e2_ok, e1_ok};

  // Software write merged with hardware-set seen flags; a set wins over a clear.
  always_comb begin
    ctrl_wr = ctrl_reg;
    if (wr && paddr == ETC_OFS_CTRL) begin
      ctrl_wr = pwdata[15:0] & ETC_CTRL_WMASK;
    end
    if (e1_ok) begin
      ctrl_wr[ETC_B_SEEN1] = 1'b1;
    end
    if (e2_ok) begin
      ctrl_wr[ETC_B_SEEN2] = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= ETC_CTRL_RST;
    end else begin
      ctrl_reg <= ctrl_wr;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_reg <= ETC_CUR_RST;
    end else if (wr && paddr == ETC_OFS_CUR) begin
      cur_reg <= pwdata[15:0] & ETC_CUR_WMASK;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_reg <= '0;
    end else if (wr && paddr == ETC_OFS_MASK) begin
      mask_reg <= pwdata[ETC_IRQ_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_reg <= '0;
    end else if (wr && paddr == ETC_OFS_STAT) begin
      stat_reg <= (stat_reg & ~pwdata[ETC_IRQ_W-1:0]) | evt;
    end else begin
      stat_reg <= stat_reg | evt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(((stat_reg | evt) & ~((wr && paddr == ETC_OFS_STAT) ? pwdata[ETC_IRQ_W-1:0] : '0) | evt)
               & mask_reg);
    end
  end

  // Delay generation: wait for first edge, charge, pulse on comparator trip.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dg_reg <= ETC_DG_IDLE;
    end else if (!active || !ctrl_reg[ETC_B_DGEN]) begin
      dg_reg <= ETC_DG_IDLE;
    end else begin
      unique case (dg_reg)
        ETC_DG_IDLE:   if (e1_ok) dg_reg <= ETC_DG_CHARGE;
        ETC_DG_CHARGE: if (comp_trip) dg_reg <= ETC_DG_DONE;
        ETC_DG_DONE:   dg_reg <= ETC_DG_IDLE;
        default:       dg_reg <= ETC_DG_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      delay_pulse_out <= 1'b0;
      charge_on       <= 1'b0;
      route_to_comp_b <= 1'b0;
      source_ground   <= 1'b0;
      current_trim    <= '0;
      current_range   <= ETC_RNG_OFF;
      trigger_out     <= 1'b0;
    end else begin
      delay_pulse_out <= pulse_evt;
      charge_on       <= active & (ctrl_reg[ETC_B_DGEN] ? (dg_reg == ETC_DG_CHARGE)
                         : (ctrl_reg[ETC_B_SEEN1] ^ ctrl_reg[ETC_B_SEEN2]));
      route_to_comp_b <= active & ctrl_reg[ETC_B_DGEN];
      source_ground   <= ctrl_reg[ETC_B_GND];
      current_trim    <= cur_reg[ETC_B_TRIM+:6];
      current_range   <= active ? cur_reg[ETC_B_RANGE+:2] : ETC_RNG_OFF;
      trigger_out     <= active & ctrl_reg[ETC_B_TRIG]
                         & (ctrl_reg[ETC_B_SEEN1] | ctrl_reg[ETC_B_SEEN2]);
    end
  end

  // APB read data is registered in the setup cycle; zero wait states.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (rd) begin
      unique case (paddr)
        ETC_OFS_CTRL: prdata <= {16'h0000, ctrl_reg};
        ETC_OFS_CUR:  prdata <= {16'h0000, cur_reg};
        ETC_OFS_STAT: prdata <= {29'h0000000, stat_reg};
        ETC_OFS_MASK: prdata <= {29'h0000000, mask_reg};
        default:      prdata <= '0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~dec_ok;
    end
  end

  property p_reserved_zero;
    @(posedge pclk) disable iff (!presetn)
      (ctrl_reg & ~ETC_CTRL_WMASK) == 16'h0000 && (cur_reg & ~ETC_CUR_WMASK) == 16'h0000;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("Reserved bit set.");

  property p_seen1_set;
    @(posedge pclk) disable iff (!presetn)
      e1_ok |=> ctrl_reg[ETC_B_SEEN1];
  endproperty
  a_seen1_set: assert property (p_seen1_set) else $error("First edge flag not set.");

  property p_seen2_set;
    @(posedge pclk) disable iff (!presetn)
      e2_ok |=> ctrl_reg[ETC_B_SEEN2];
  endproperty
  a_seen2_set: assert property (p_seen2_set) else $error("Second edge flag not set.");

  property p_order;
    @(posedge pclk) disable iff (!presetn)
      (ctrl_reg[ETC_B_ORDER] && !ctrl_reg[ETC_B_SEEN1] && !ctrl_reg[ETC_B_SEEN2] && !e1_ok)
        |=> !ctrl_reg[ETC_B_SEEN2] || $past(wr);
  endproperty
  a_order: assert property (p_order) else $error("Second edge taken out of order.");

  property p_block;
    @(posedge pclk) disable iff (!presetn)
      !ctrl_reg[ETC_B_PASS] |-> !e1_ok && !e2_ok;
  endproperty
  a_block: assert property (p_block) else $error("Edge passed while blocked.");

  property p_pulse;
    @(posedge pclk) disable iff (!presetn)
      (dg_reg == ETC_DG_CHARGE && comp_trip) |=> delay_pulse_out ##1 !delay_pulse_out;
  endproperty
  a_pulse: assert property (p_pulse) else $error("Delay pulse wrong.");

  property p_route;
    @(posedge pclk) disable iff (!presetn)
      $rose(ctrl_reg[ETC_B_DGEN]) && active |=> route_to_comp_b;
  endproperty
  a_route: assert property (p_route) else $error("Current not routed to comparator.");

  property p_disabled;
    @(posedge pclk) disable iff (!presetn)
      !ctrl_reg[ETC_B_EN] ##1 !ctrl_reg[ETC_B_EN] |-> !trigger_out && !route_to_comp_b;
  endproperty
  a_disabled: assert property (p_disabled) else $error("Unit active while disabled.");

  property p_idle;
    @(posedge pclk) disable iff (!presetn)
      ctrl_reg[ETC_B_IDLE] && idle_mode |-> !e1_ok && !e2_ok;
  endproperty
  a_idle: assert property (p_idle) else $error("Edge taken in idle halt.");

  property p_ground_on;
    @(posedge pclk) disable iff (!presetn)
      ctrl_reg[ETC_B_GND] |=> source_ground;
  endproperty
  a_ground_on: assert property (p_ground_on) else $error("Current source not grounded.");

  property p_ground_off;
    @(posedge pclk) disable iff (!presetn)
      !ctrl_reg[ETC_B_GND] |=> !source_ground;
  endproperty
  a_ground_off: assert property (p_ground_off) else $error("Current source grounded.");

  property p_trig_off;
    @(posedge pclk) disable iff (!presetn)
      !ctrl_reg[ETC_B_TRIG] |=> !trigger_out;
  endproperty
  a_trig_off: assert property (p_trig_off) else $error("Trigger out while disabled.");

  property p_range_off;
    @(posedge pclk) disable iff (!presetn)
      !active |=> current_range == ETC_RNG_OFF;
  endproperty
  a_range_off: assert property (p_range_off) else $error("Current source on while unit inactive.");

  property p_range_follow;
    @(posedge pclk) disable iff (!presetn)
      active |=> current_range == $past(cur_reg[ETC_B_RANGE+:2]);
  endproperty
  a_range_follow: assert property (p_range_follow) else $error("Range differs from register.");

  property p_trim_follow;
    @(posedge pclk) disable iff (!presetn)
      1'b1 |=> current_trim == $past(cur_reg[ETC_B_TRIM+:6]);
  endproperty
  a_trim_follow: assert property (p_trim_follow) else $error("Trim differs from register.");

  property p_seen1_hold;
    @(posedge pclk) disable iff (!presetn)
      ctrl_reg[ETC_B_SEEN1] && !(wr && paddr == ETC_OFS_CTRL) |=> ctrl_reg[ETC_B_SEEN1];
  endproperty
  a_seen1_hold: assert property (p_seen1_hold) else $error("First edge flag lost.");

  property p_seen2_hold;
    @(posedge pclk) disable iff (!presetn)
      ctrl_reg[ETC_B_SEEN2] && !(wr && paddr == ETC_OFS_CTRL) |=> ctrl_reg[ETC_B_SEEN2];
  endproperty
  a_seen2_hold: assert property (p_seen2_hold) else $error("Second edge flag lost.");

  property p_route_off;
    @(posedge pclk) disable iff (!presetn)
      !ctrl_reg[ETC_B_DGEN] |=> !route_to_comp_b;
  endproperty
  a_route_off: assert property (p_route_off) else $error("Current routed without delay mode.");

  property p_charge_start;
    @(posedge pclk) disable iff (!presetn)
      active && ctrl_reg[ETC_B_DGEN] && dg_reg == ETC_DG_IDLE && e1_ok |=> dg_reg == ETC_DG_CHARGE;
  endproperty
  a_charge_start: assert property (p_charge_start) else $error("Charge not started on edge.");

  property p_pulse_cause;
    @(posedge pclk) disable iff (!presetn)
      delay_pulse_out |-> $past(dg_reg) == ETC_DG_CHARGE && $past(comp_trip);
  endproperty
  a_pulse_cause: assert property (p_pulse_cause) else $error("Delay pulse without comparator trip.");

  property p_idle_range;
    @(posedge pclk) disable iff (!presetn)
      ctrl_reg[ETC_B_IDLE] && idle_mode |=> current_range == ETC_RNG_OFF;
  endproperty
  a_idle_range: assert property (p_idle_range) else $error("Current source on in idle halt.");
endmodule : etc_top

// [test/etc_far_side.sv]
// Purpose: Far side model: edge source levels and the delay comparator.
// Assumes: Bench sets source levels and the trip delay.
// Notes:   Trips only while charging, ungrounded, with range on.
`timescale 1ns/1ns
module etc_far_side (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [3:0] edge_req,
  input  wire logic       charge_on,
  input  wire logic       source_ground,
  input  wire logic [1:0] current_range,
  input  wire logic [7:0] trip_cycles,
  output logic      [3:0] src_lvl,
  output logic            comp_trip
);
  logic [7:0] cnt_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_lvl   <= 4'h0;
      cnt_reg   <= 8'h00;
      comp_trip <= 1'b0;
    end else begin
      src_lvl   <= edge_req;
      cnt_reg   <= (charge_on && !source_ground && current_range != 2'h0) ? cnt_reg + 8'h01 : 8'h00;
      comp_trip <= (cnt_reg != 8'h00) && (cnt_reg >= trip_cycles);
    end
  end
endmodule : etc_far_side

// [test/etc_top_test.sv]
// Purpose: Self-checking bench for the charge control block.
// Assumes: APB master waits for pready; far side model drives sources.
// Notes:   Outputs are looked at a few cycles after each transfer.
`timescale 1ns/1ns
module etc_top_test;
  import etc_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, idle_mode, comp_trip, err;
  logic        charge_on, route_to_comp_b, source_ground, trigger_out, delay_pulse_out, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [5:0]  current_trim;
  logic [1:0]  current_range;
  logic [3:0]  edge_req, src_lvl;
  logic [7:0]  trip_cycles;
  int          failures, checks_done, n;
  etc_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .idle_mode(idle_mode),
    .timer_evt(src_lvl[0]), .ocmp_evt(src_lvl[1]), .ext_edge_pin_two(src_lvl[2]), .ext_edge_pin_one(src_lvl[3]),
    .comp_trip(comp_trip), .charge_on(charge_on), .route_to_comp_b(route_to_comp_b), .source_ground(source_ground),
    .current_trim(current_trim), .current_range(current_range), .trigger_out(trigger_out),
    .delay_pulse_out(delay_pulse_out), .irq(irq));
  etc_far_side far (.pclk(pclk), .presetn(presetn), .edge_req(edge_req), .charge_on(charge_on),
    .source_ground(source_ground), .current_range(current_range), .trip_cycles(trip_cycles),
    .src_lvl(src_lvl), .comp_trip(comp_trip));
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  task automatic stop_test();
    if (failures == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : stop_test
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    if (pready !== 1'b1) begin
      failures++;
      stop_test();
    end
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask : apb
  task automatic lvl(input int s, input logic v);
    @(posedge pclk);
    edge_req[s] <= v;
    repeat (4) @(posedge pclk);
  endtask : lvl
  task automatic t_regs();
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, 12'(i * 4), 32'h0);
      chk("reset value", 32'h0, rd);
    end
    apb(1'b0, 12'h010, 32'hFFFF_FFFF);
    chk("unmapped error", 32'h1, 32'(err));
    chk("unmapped data", 32'h0, rd);
    apb(1'b1, ETC_OFS_CTRL, 32'hFFFF_FFFF);
    apb(1'b0, ETC_OFS_CTRL, 32'h0);
    chk("control", 32'h0000_BFFF, rd);
    chk("ground", 32'h1, 32'(source_ground));
    chk("route", 32'h1, 32'(route_to_comp_b));
    chk("trigger", 32'h1, 32'(trigger_out));
    apb(1'b1, ETC_OFS_CUR, 32'hFFFF_FFFF);
    apb(1'b0, ETC_OFS_CUR, 32'h0);
    chk("current", 32'h0000_FF00, rd);
    apb(1'b1, ETC_OFS_CTRL, 32'h0000_0103);
    chk("trigger off", 32'h0, 32'(trigger_out));
    chk("range off", 32'h0, 32'(current_range));
    chk("ground off", 32'h0, 32'(source_ground));
  endtask : t_regs
  task automatic t_range();
    for (int r = 0; r < 4; r++) begin
      apb(1'b1, ETC_OFS_CTRL, 32'h8000);
      apb(1'b1, ETC_OFS_CUR, 32'({(r % 2) ? 6'h1F : 6'h21, 2'(r), 8'h00}));
      chk("range", 32'(r), 32'(current_range));
      chk("trim", (r % 2) ? 32'h1F : 32'h21, 32'(current_trim));
    end
    idle_mode <= 1'b1;
    apb(1'b1, ETC_OFS_CTRL, 32'hA000);
    chk("range idle", 32'h0, 32'(current_range));
    idle_mode <= 1'b0;
  endtask : t_range
  task automatic t_block();
    logic [15:0] cfg [4];
    cfg = '{16'h0810, 16'h8010, 16'hA810, 16'h8810};
    for (int i = 0; i < 4; i++) begin
      idle_mode <= (i >= 2);
      edge_req  <= 4'h0;
      apb(1'b1, ETC_OFS_CTRL, 32'(cfg[i]));
      lvl(0, 1'b1);
      apb(1'b0, ETC_OFS_CTRL, 32'h0);
      chk("seen gated", 32'(i == 3), 32'(rd[0]));
    end
    idle_mode <= 1'b0;
  endtask : t_block
  task automatic t_edges();
    logic [15:0] c;
    for (int e = 0; e < 2; e++) for (int s = 0; s < 4; s++) for (int p = 0; p < 2; p++) begin
      c = 16'h8800 | 16'(p << (e ? 7 : 4)) | 16'(s << (e ? 5 : 2));
      edge_req <= p ? 4'h0 : 4'hF;
      apb(1'b1, ETC_OFS_CTRL, 32'(c));
      lvl((s + 1) % 4, p[0]);
      apb(1'b0, ETC_OFS_CTRL, 32'h0);
      chk("seen other source", 32'h0, 32'(rd[e]));
      lvl(s, p[0]);
      apb(1'b0, ETC_OFS_CTRL, 32'h0);
      chk("seen", 32'h1, 32'(rd[e]));
      lvl(s, ~p[0]);
      apb(1'b0, ETC_OFS_CTRL, 32'h0);
      chk("seen held", 32'h1, 32'(rd[e]));
    end
  endtask : t_edges
  task automatic t_order();
    edge_req <= 4'h0;
    apb(1'b1, ETC_OFS_STAT, 32'h7);
    apb(1'b1, ETC_OFS_CTRL, 32'h8CF0);
    lvl(3, 1'b1);
    apb(1'b0, ETC_OFS_CTRL, 32'h0);
    chk("second early", 32'h0, 32'(rd[1]));
    lvl(0, 1'b1);
    chk("charging", 32'h1, 32'(charge_on));
    lvl(3, 1'b0);
    lvl(3, 1'b1);
    chk("charge stopped", 32'h0, 32'(charge_on));
    apb(1'b0, ETC_OFS_STAT, 32'h0);
    chk("status edges", 32'h3, rd);
  endtask : t_order
  task automatic t_delay();
    for (int k = 0; k < 2; k++) begin
      trip_cycles <= k ? 8'd20 : 8'd1;
      edge_req    <= 4'h0;
      apb(1'b1, ETC_OFS_MASK, 32'h0);
      apb(1'b1, ETC_OFS_CUR, 32'h0100);
      apb(1'b1, ETC_OFS_CTRL, 32'h9810);
      apb(1'b1, ETC_OFS_STAT, 32'h7);
      chk("route", 32'h1, 32'(route_to_comp_b));
      edge_req[0] <= 1'b1;
      n = 0;
      while (delay_pulse_out !== 1'b1 && n < 200) begin
        @(posedge pclk);
        n++;
      end
      chk("pulse delay", 32'h1, 32'(n > trip_cycles && n < 200));
      if (n >= 200) stop_test();
      @(posedge pclk);
      chk("pulse width", 32'h0, 32'(delay_pulse_out));
      chk("charge end", 32'h0, 32'(charge_on));
      apb(1'b0, ETC_OFS_STAT, 32'h0);
      chk("status", 32'h5, rd);
      chk("irq masked", 32'h0, 32'(irq));
      apb(1'b1, ETC_OFS_MASK, 32'h4);
      chk("irq", 32'h1, 32'(irq));
      apb(1'b1, ETC_OFS_STAT, 32'h7);
      chk("irq cleared", 32'h0, 32'(irq));
    end
  endtask : t_delay
  initial begin
    presetn     = 1'b0;
    psel        = 1'b0;
    penable     = 1'b0;
    pwrite      = 1'b0;
    paddr       = 12'h000;
    pwdata      = 32'h0;
    idle_mode   = 1'b0;
    edge_req    = 4'h0;
    trip_cycles = 8'd4;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_range();
    t_block();
    t_edges();
    t_order();
    t_delay();
    stop_test();
  end
endmodule : etc_top_test
